// ==== camera_pin_trigger_context_control.sv ====
// pin mux, output enable, trigger source and context sequencer
// assumes synchronous inputs and a host that drives the config ports
`timescale 1ns/1ns
`include "camera_control_params.svh"
module camera_pin_trigger_context_control
	import camera_control_pkg::*;
#(
	parameter int PINS = `PIN_COUNT
)(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// host configuration
	input wire pin_map_e pinMap,
	input wire logic [PINS-1:0] inputEnable,
	input wire logic [PINS-1:0] pulseOut,
	input wire logic outputEnableReg,
	input wire logic useOePin,
	input wire logic globalTrigger,
	input wire logic triggerPinEnable,
	input wire logic [2:0] triggerPinSel,
	input wire logic contextSwitch,
	input wire context_b_s contextB,
	input wire logic antiShake,
	input wire logic motion,
	input wire sensor_s sensorIn,
	// sensor side
	input wire logic [1:0] pixelLsb,
	input wire logic shutterIn,
	input wire logic frameEnd,
	input wire logic parallelEnable,
	// camera control pins
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe_n,
	// status
	output logic [PINS-1:0] generalInput,
	output logic pixelOe_n,
	output logic trigger,
	output logic contextIsB,
	output logic fullRes,
	output logic ledOn,
	output logic autoFuncs,
	output logic shutterSel,
	output logic flashSel,
	output sensor_s sensorOut
);
	logic [PINS-1:0] next_pinOut, next_pinOe_n, next_generalInput;
	logic next_pixelOe_n, next_trigger, next_shutterSel, next_flashSel;
	seq_e state, next_state;
	logic [3:0] frames, next_frames;
	sensor_s next_sensorOut;
	logic next_contextIsB, next_fullRes, next_ledOn, next_autoFuncs;

	// pin function mux; all-input map is also the reset map
	always_comb
	begin
		next_pinOut = '0;
		next_pinOe_n = '1;
		next_generalInput = '0;
		next_shutterSel = shutterSel;
		next_flashSel = flashSel;
		case (pinMap)
			MAP_STD_IN:
			begin
				next_shutterSel = pinIn[`PIN_SHUTTER_SEL];
				next_flashSel = pinIn[`PIN_FLASH_SEL];
				for (int i = 3; i < PINS; i++)
					next_generalInput[i] = pinIn[i] & inputEnable[i];
			end
			MAP_STD_OUT:
			begin
				next_pinOe_n = '0;
				next_pinOut[1:0] = pixelLsb;
				next_pinOut[`PIN_SHUTTER_OUT] = shutterIn;
				next_pinOut[`PIN_FLASH_OUT] = ledOn;
				next_pinOut[PINS-1:4] = pulseOut[PINS-1:4];
			end
			MAP_ALL_IN:
				next_generalInput = pinIn & inputEnable;
			default:
			begin
				next_pinOe_n = '0;
				next_pinOut = pulseOut;
			end
		endcase
		// pin 2 acts only in the standard input map; low enables
		if (!parallelEnable)
			next_pixelOe_n = 1'b1;
		else if (useOePin && pinMap == MAP_STD_IN)
			next_pixelOe_n = pinIn[`PIN_OE];
		else
			next_pixelOe_n = !outputEnableReg;
		// register bit or enabled trigger pin
		next_trigger = globalTrigger | (triggerPinEnable & pinIn[triggerPinSel]);
	end

	// capture sequencer: preview, optional flash frame, capture frames
	always_comb
	begin
		next_state = state;
		next_frames = frames;
		case (state)
			SEQ_PREVIEW:
				if (contextSwitch)
				begin
					next_frames = contextB.frameCount;
					next_state = contextB.flashUse ? SEQ_FLASH : SEQ_CAPTURE;
				end
			SEQ_FLASH:
				if (frameEnd)
					next_state = SEQ_CAPTURE;
			default:
				if (contextSwitch)
					next_state = SEQ_PREVIEW; // video exit by command
				else if (frameEnd)
				begin
					if (frames <= 4'h1)
						next_state = SEQ_PREVIEW;
					else
						next_frames = frames - 4'h1;
				end
		endcase
		// status follows the next state, so it leaves a flop with no extra lag
		next_contextIsB = next_state != SEQ_PREVIEW;
		next_fullRes = next_state != SEQ_PREVIEW;
		next_ledOn = next_state == SEQ_FLASH || (next_state == SEQ_CAPTURE && contextB.flashUse);
		next_autoFuncs = next_state == SEQ_PREVIEW;
		// motion trades exposure for gain
		next_sensorOut = sensorIn;
		if (antiShake && motion)
		begin
			next_sensorOut.gain = sensorIn.gain << `EXP_SHIFT;
			next_sensorOut.exposure = sensorIn.exposure >> `EXP_SHIFT;
		end
	end

	// pin group registers; clkEn freezes everything, pins float in reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pinOut <= '0;
			pinOe_n <= '1;
			generalInput <= `PIN_DEFAULT_IN;
			pixelOe_n <= 1'b1;
			trigger <= 1'b0;
			shutterSel <= 1'b0;
			flashSel <= 1'b0;
		end
		else if (clkEn)
		begin
			pinOut <= next_pinOut;
			pinOe_n <= next_pinOe_n;
			generalInput <= next_generalInput;
			pixelOe_n <= next_pixelOe_n;
			trigger <= next_trigger;
			shutterSel <= next_shutterSel;
			flashSel <= next_flashSel;
		end
	end

	// sequencer group registers; reset lands in preview
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= SEQ_PREVIEW;
			frames <= '0;
			contextIsB <= 1'b0;
			fullRes <= 1'b0;
			ledOn <= 1'b0;
			autoFuncs <= 1'b1;
			sensorOut <= '0;
		end
		else if (clkEn)
		begin
			state <= next_state;
			frames <= next_frames;
			contextIsB <= next_contextIsB;
			fullRes <= next_fullRes;
			ledOn <= next_ledOn;
			autoFuncs <= next_autoFuncs;
			sensorOut <= next_sensorOut;
		end
	end

	// checks
	trig_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && globalTrigger |=> trigger)
		else $error("register trigger missed");
	trig_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !globalTrigger && !triggerPinEnable |=> !trigger)
		else $error("trigger without source");
	ctx_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && state == SEQ_PREVIEW && contextSwitch |=> contextIsB && fullRes)
		else $error("context switch missed");
	ctx_return_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && state == SEQ_CAPTURE && frameEnd && frames <= 4'h1 && !contextSwitch |=> !contextIsB)
		else $error("no return to preview");
	pin_allin_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && pinMap == MAP_ALL_IN |=> pinOe_n == '1)
		else $error("pin driven in input map");
	pin_allout_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && pinMap == MAP_ALL_OUT |=> pinOe_n == '0 && pinOut == $past(pulseOut))
		else $error("pulse output wrong");
	oe_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && parallelEnable && useOePin && pinMap == MAP_STD_IN |=> pixelOe_n == $past(pinIn[`PIN_OE]))
		else $error("oe pin not followed");
	gpi_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && pinMap == MAP_ALL_IN |=> generalInput == ($past(pinIn) & $past(inputEnable)))
		else $error("general input level wrong");
	shake_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && antiShake && motion |=> sensorOut.exposure == ($past(sensorIn.exposure) >> 1))
		else $error("exposure not shortened");
	std_out_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && pinMap == MAP_STD_OUT |=> pinOe_n == '0 && pinOut[1:0] == $past(pixelLsb))
		else $error("standard output map wrong");
	flash_led_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && state == SEQ_PREVIEW && contextSwitch && contextB.flashUse |=> ledOn && state == SEQ_FLASH)
		else $error("flash not lit on capture");
	pix_float_a: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !parallelEnable |=> pixelOe_n)
		else $error("pixel bus driven while disabled");
	// a frozen cycle must not let any group slip by one edge
	freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!clkEn |=> $stable(state) && $stable(pinOe_n) && $stable(generalInput))
		else $error("state moved while frozen");
endmodule // camera_pin_trigger_context_control

// ==== camera_control_params.svh ====
// constants for the camera pin, trigger and context control block
// assumes one 25 MHz clock and a host that drives the config ports
// Functional notes
// - eight camera control pins, each host-programmable to several functions
// - standard input/output maps per pin; all pins default to general inputs
// - optional mode: all eight pins plain general inputs, core unused
// - optional mode: all eight pins general pulse outputs, core unused
// - serial-master focus leaves two pins for flash and shutter
// - host enables or disables each general input
// - current level of general inputs readable
// - pixel outputs switch driven/high-impedance by pin or register bit
// - global reset sequence starts from pin or register trigger
// - trigger when register bit 1 or enabled trigger pin reads 1
// - sequencer: capture goes full resolution, LED, back to preview after frame
// - two contexts A and B, switched by host command
// - context A is preview: low resolution, low power, automatic functions on
// - context B configurable: size, flash use, frame count; the size field has no effect in the block and fullRes is set for any size
// - anti-shake: motion raises sensitivity, shortens exposure
// - after context B frames, return to context A preview
`ifndef CAMERA_CONTROL_PARAMS_SVH
`define CAMERA_CONTROL_PARAMS_SVH
`define PIN_COUNT 8
`define PIN_DEFAULT_IN 8'h00
`define PIN_SHUTTER_SEL 0
`define PIN_FLASH_SEL 1
`define PIN_OE 2
`define PIN_FLASH_OUT 3
`define PIN_SHUTTER_OUT 2
`define EXP_SHIFT 1
`endif

// ==== camera_control_pkg.sv ====
// types for the camera pin, trigger and context control block
// assumes nothing beyond the params header
package camera_control_pkg;
	typedef enum logic [1:0] {MAP_STD_IN, MAP_STD_OUT, MAP_ALL_IN, MAP_ALL_OUT} pin_map_e;
	typedef enum logic [1:0] {SEQ_PREVIEW, SEQ_FLASH, SEQ_CAPTURE} seq_e;
	typedef struct packed {
		logic [1:0] size;
		logic flashUse;
		logic [3:0] frameCount;
	} context_b_s;
	typedef struct packed {
		logic [7:0] gain;
		logic [7:0] exposure;
	} sensor_s;
endpackage

// ==== host_model.sv ====
// host-side model: context commands and frame-end pulses
// assumes calls land just after a rising edge of clk
`timescale 1ns/1ns
module host_model (
	// clock
	input wire logic clk,
	// toward the block
	output logic contextSwitch,
	output logic frameEnd
);
	// idle until asked
	initial
	begin
		contextSwitch = 1'b0;
		frameEnd = 1'b0;
	end
	// context change is a one-cycle command
	task automatic cmd();
		contextSwitch = 1'b1;
		@(posedge clk);
		#1 contextSwitch = 1'b0;
	endtask
	// one frame end, then a quiet cycle so the state can settle
	task automatic frame();
		frameEnd = 1'b1;
		@(posedge clk);
		#1 frameEnd = 1'b0;
		@(posedge clk);
		#1;
	endtask
endmodule // host_model

// ==== camera_pin_trigger_context_control_tb_top.sv ====
// bench for the camera pin, trigger and context block
// assumes registered outputs one cycle after inputs
`timescale 1ns/1ns
module camera_pin_trigger_context_control_tb_top;
	import camera_control_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, outputEnableReg = 1'b0, useOePin = 1'b0;
	logic globalTrigger = 1'b0, triggerPinEnable = 1'b0, antiShake = 1'b0, motion = 1'b0;
	logic shutterIn = 1'b0, parallelEnable = 1'b1, contextSwitch, frameEnd;
	logic trigger, contextIsB, fullRes, ledOn, autoFuncs, shutterSel, flashSel, pixelOe_n;
	logic [2:0] triggerPinSel = 3'h5;
	logic [1:0] pixelLsb = 2'h0;
	logic [7:0] inputEnable = 8'h00, pulseOut = 8'h00, pinIn = 8'h00, pinOut, pinOe_n, generalInput;
	pin_map_e pinMap = MAP_ALL_IN;
	context_b_s contextB = '0;
	sensor_s sensorIn = '0, sensorOut;
	int nFail = 0, checksDone = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	camera_pin_trigger_context_control u_camera_pin_trigger_context_control (.clk(clk), .sys_rst(sys_rst),
		.clkEn(clkEn), .pinMap(pinMap), .inputEnable(inputEnable), .pulseOut(pulseOut),
		.outputEnableReg(outputEnableReg), .useOePin(useOePin), .globalTrigger(globalTrigger),
		.triggerPinEnable(triggerPinEnable), .triggerPinSel(triggerPinSel), .contextSwitch(contextSwitch),
		.contextB(contextB), .antiShake(antiShake), .motion(motion), .sensorIn(sensorIn),
		.pixelLsb(pixelLsb), .shutterIn(shutterIn), .frameEnd(frameEnd), .parallelEnable(parallelEnable),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .generalInput(generalInput),
		.pixelOe_n(pixelOe_n), .trigger(trigger), .contextIsB(contextIsB), .fullRes(fullRes),
		.ledOn(ledOn), .autoFuncs(autoFuncs), .shutterSel(shutterSel), .flashSel(flashSel),
		.sensorOut(sensorOut));
	host_model u_host_model (.clk(clk), .contextSwitch(contextSwitch), .frameEnd(frameEnd));
	// one edge, then step past it so registered outputs have landed
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			nFail++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// every combination of enable, pin level and register bit
	task automatic t_trigger();
		inputEnable = 8'hff;
		for (int i = 0; i < 8; i++)
		begin
			{triggerPinEnable, pinIn[5], globalTrigger} = i[2:0];
			tick();
			chk(trigger, globalTrigger | (triggerPinEnable & pinIn[5]));
		end
	endtask
	task automatic t_pins();
		inputEnable = 8'h0f;
		pinIn = 8'ha5;
		tick();
		chk({pinOe_n, generalInput}, 16'hff05);
		pinMap = MAP_ALL_OUT;
		pulseOut = 8'h3c;
		tick();
		chk({pinOe_n, pinOut}, 16'h003c);
	endtask
	// pin 2 low drives the pixel bus, high floats it
	task automatic t_oe();
		pinMap = MAP_STD_IN;
		useOePin = 1'b1;
		pinIn = 8'h00;
		tick();
		chk(pixelOe_n, 1'b0);
		pinIn = 8'h04;
		tick();
		chk(pixelOe_n, 1'b1);
		pinIn = 8'h0d;
		tick();
		chk({pixelOe_n, shutterSel, flashSel, generalInput}, 16'h0608);
		useOePin = 1'b0;
		outputEnableReg = 1'b1;
		tick();
		chk(pixelOe_n, 1'b0);
		parallelEnable = 1'b0;
		tick();
		chk(pixelOe_n, 1'b1);
		parallelEnable = 1'b1;
	endtask
	// standard output map: pixel bits, shutter, idle flash lamp, pulse pins
	task automatic t_stdout();
		pinMap = MAP_STD_OUT;
		pixelLsb = 2'h2;
		shutterIn = 1'b1;
		pulseOut = 8'ha0;
		tick();
		chk({pinOe_n, pinOut}, 16'h00a6);
		pinMap = MAP_STD_IN;
	endtask
	// one flash capture, then video entered and left by command
	task automatic t_flash();
		contextB = '{size: 2'h1, flashUse: 1'b1, frameCount: 4'h1};
		u_host_model.cmd();
		chk({contextIsB, ledOn}, 2'b11);
		u_host_model.frame();
		chk({contextIsB, ledOn}, 2'b11);
		u_host_model.frame();
		chk({contextIsB, ledOn, autoFuncs}, 3'b001);
		contextB = '{size: 2'h2, flashUse: 1'b0, frameCount: 4'hf};
		u_host_model.cmd();
		u_host_model.frame();
		chk(contextIsB, 1'b1);
		u_host_model.cmd();
		chk({contextIsB, fullRes}, 2'b00);
	endtask
	// clock enable low holds every flop while inputs move
	task automatic t_freeze();
		pinMap = MAP_ALL_IN;
		inputEnable = 8'hff;
		pinIn = 8'h11;
		tick();
		clkEn = 1'b0;
		pinIn = 8'h22;
		u_host_model.cmd();
		chk({contextIsB, generalInput}, 16'h0011);
		clkEn = 1'b1;
		tick();
		chk(generalInput, 8'h22);
	endtask
	// two-frame capture without flash, then back to preview
	task automatic t_context();
		contextB = '{size: 2'h3, flashUse: 1'b0, frameCount: 4'h2};
		u_host_model.cmd();
		chk({contextIsB, fullRes, autoFuncs}, 3'b110);
		u_host_model.frame();
		chk(contextIsB, 1'b1);
		u_host_model.frame();
		chk({contextIsB, fullRes, autoFuncs}, 3'b001);
	endtask
	task automatic t_shake();
		antiShake = 1'b1;
		motion = 1'b1;
		sensorIn = '{gain: 8'h10, exposure: 8'h40};
		tick();
		chk(sensorOut, 16'h2020);
	endtask
	// watchdog well beyond the few dozen cycles the tests need
	initial
	begin
		#100000;
		nFail++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		chk({pinOe_n, generalInput}, 16'hff00);
		chk({contextIsB, autoFuncs, trigger}, 3'b010);
		t_trigger();
		t_pins();
		t_oe();
		t_stdout();
		t_context();
		t_flash();
		t_freeze();
		t_shake();
		report_and_stop();
	end
endmodule // camera_pin_trigger_context_control_tb_top
